// ### logic/port_mac_interface_config.sv
// Per-port MAC and external interface configuration register bank
`timescale 1ns/1ps
`include "port_mac_cfg_params.svh"
// Function
// RULE1 - Duplex bit: set full, clear half, default full
// RULE2 - Transmit flow control follows its enable bit
// RULE3 - 10/100 bit ignored when gigabit selected
// RULE4 - 10/100 bit: set 100, clear 10, default set
// RULE5 - Receive flow control follows its enable bit
// RULE6 - Flow control defaults come from a strap
// RULE7 - Gigabit field inverted: clear means 1000, strapped
// RULE8 - Ingress clock delay bit, default clear
// RULE9 - Egress clock delay bit, default set
// RULE10 - MII: role set receives clocks, clear drives
// RULE11 - RMII: role set reference in, clear out
// RULE12 - Type field: 00 RGMII, 01 RMII, else MII
// RULE13 - Broadcast storm protection enable, default off
// RULE14 - Back pressure only acts in half duplex
// RULE15 - Pass-all forwards bad frames for mirroring
// RULE16 - Pass-all leaves flow control filtering alone
// RULE17 - Straps sampled at reset, loaded before access
module port_mac_interface_config
    import port_mac_cfg_pkg::*;
(
    input  wire logic             mclk,
    input  wire logic             rst_n,
    input  wire bus_req_t         bus,
    output logic      [7:0]       rdata,
    input  wire logic             flow_control_default_strap,
    input  wire logic             port6_speed_strap,
    input  wire logic             port7_speed_strap,
    input  wire logic             port6_clock_role_strap,
    input  wire logic             port7_clock_role_strap,
    input  wire logic [1:0]       port6_interface_type_strap,
    input  wire logic [1:0]       port7_interface_type_strap,
    input  wire logic [`NEXT-1:0] receive_clock_pin_i,
    output logic      [`NEXT-1:0] receive_clock_pin_o,
    output logic      [`NEXT-1:0] receive_clock_pin_oe,
    output logic      [`NEXT-1:0] link_clock_active,
    output port_cfg_t             port_cfg [`NPORTS]
);
    ////////////////////////////////////////////////////////////////////////
    // Storage and decode
    logic [7:0]  ctrl_a_q  [`NEXT];
    logic [7:0]  ctrl_b_q  [`NEXT];
    logic [7:0]  mac_a_q   [`NPORTS];
    logic [7:0]  mac_b_q   [`NPORTS];
    logic        strap_done_q;
    logic [3:0]  pnum;
    logic [11:0] ofs;
    logic        port_ok;
    logic [2:0]  pidx;
    logic        eidx;
    logic        ext_ok;
    logic [7:0]  rd_d;
    logic [1:0]  spd_strap;
    logic [1:0]  role_strap;
    logic [1:0]  type_strap [`NEXT];

    assign pnum          = bus.addr[15:12];
    assign ofs           = bus.addr[11:0];
    assign port_ok       = (pnum >= `PORT_MIN) && (pnum <= `PORT_MAX);
    assign pidx          = 3'(pnum - `PORT_MIN);
    assign eidx          = (pidx == `EXT_LAST_IDX);
    assign ext_ok        = port_ok && (pidx >= 3'(`EXT_BASE));
    assign spd_strap     = {port7_speed_strap, port6_speed_strap};
    assign role_strap    = {port7_clock_role_strap, port6_clock_role_strap};
    assign type_strap[0] = port6_interface_type_strap;
    assign type_strap[1] = port7_interface_type_strap;

    // Straps sit still across reset; catch them on the first edge after release
    // Strap load completes at the first edge after reset
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            strap_done_q <= 1'b0;
        else
            strap_done_q <= 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////
    // Per-port MAC control registers, ports 1 to 7
    genvar p;
    generate
        for (p = 0; p < `NPORTS; p++)
        begin : g_port
            logic hit;
            assign hit = bus.we && port_ok && (pidx == 3'(p));

            // Software writes; read-only bits never store
            always_ff @(posedge mclk or negedge rst_n)
            begin
                if (!rst_n)
                begin
                    mac_a_q[p] <= `MA_RST;
                    mac_b_q[p] <= `MB_RST;
                end
                else if (hit && ofs == `MAC_A_OFS)
                    mac_a_q[p] <= bus.wdata & `MA_WMASK;
                else if (hit && ofs == `MAC_B_OFS)
                    mac_b_q[p] <= bus.wdata & `MB_WMASK;
            end

            if (p < `EXT_BASE)
            begin : g_int
                // Internal ports: fixed full duplex 100, MII-like, no fc enables
                always_ff @(posedge mclk or negedge rst_n)
                begin
                    if (!rst_n)
                        port_cfg[p] <= '{SPD_100, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0,
                                         1'b0, 1'b0, 1'b0, 1'b1, IF_MII};
                    else
                    begin
                        // RULE13 storm enable
                        port_cfg[p].storm_en     <= mac_a_q[p][`MA_STORM];
                        // RULE14 half duplex only
                        port_cfg[p].backpressure <= 1'b0;
                        // RULE15 RULE16 mirror only
                        port_cfg[p].pass_bad     <= mac_b_q[p][`MB_PASSALL];
                    end
                end
            end
            else
            begin : g_ext
                localparam int E = p - `EXT_BASE;
                logic [7:0] ca;
                logic [7:0] cb;
                assign ca = ctrl_a_q[E];
                assign cb = ctrl_b_q[E];

                // Effective settings of the external port
                always_ff @(posedge mclk or negedge rst_n)
                begin
                    if (!rst_n)
                        port_cfg[p] <= '{SPD_100, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0,
                                         1'b0, 1'b0, 1'b1, 1'b0, IF_RGMII};
                    else
                    begin
                        // RULE3 RULE4 RULE7 speed pick
                        if (!cb[`CB_GIG])
                            port_cfg[p].speed <= SPD_1000;
                        else if (ca[`CA_SPD100])
                            port_cfg[p].speed <= SPD_100;
                        else
                            port_cfg[p].speed <= SPD_10;
                        // RULE1 duplex select
                        port_cfg[p].full_duplex <= ca[`CA_DUPLEX];
                        // RULE2 transmit flow control
                        port_cfg[p].tx_fc_en <= ca[`CA_TXFC];
                        // RULE5 receive flow control
                        port_cfg[p].rx_fc_en <= ca[`CA_RXFC];
                        // RULE14 half duplex only
                        port_cfg[p].backpressure <= mac_b_q[p][`MB_BACKPR] &
                                                    ~ca[`CA_DUPLEX];
                        // RULE13 storm enable
                        port_cfg[p].storm_en <= mac_a_q[p][`MA_STORM];
                        // RULE15 RULE16 mirror only
                        port_cfg[p].pass_bad <= mac_b_q[p][`MB_PASSALL];
                        // RULE8 ingress delay
                        port_cfg[p].rx_clock_delay_enable <= cb[`CB_RXDLY];
                        // RULE9 egress delay
                        port_cfg[p].tx_clock_delay_enable <= cb[`CB_TXDLY];
                        // RULE10 RULE11 clock role
                        port_cfg[p].clocks_in <= cb[`CB_ROLE];
                        // RULE12 type decode
                        unique case (cb[`CB_TYPE_HI:`CB_TYPE_LO])
                            2'b00:   port_cfg[p].mode <= IF_RGMII;
                            2'b01:   port_cfg[p].mode <= IF_RMII;
                            default: port_cfg[p].mode <= IF_MII;
                        endcase
                    end
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // External interface registers and link clock pin, ports 6 and 7
    genvar e;
    generate
        for (e = 0; e < `NEXT; e++)
        begin : g_ext_if
            logic       hit;
            logic       rclk_s;
            logic       rclk_prev_q;
            logic [5:0] idle_q;
            logic       drive_q;
            assign hit = bus.we && ext_ok && (eidx == 1'(e));

            // RULE17 strap load first
            // RULE6 strapped flow control
            always_ff @(posedge mclk or negedge rst_n)
            begin
                if (!rst_n)
                    ctrl_a_q[e] <= `CA_RST;
                else if (!strap_done_q)
                begin
                    ctrl_a_q[e][`CA_TXFC] <= flow_control_default_strap;
                    ctrl_a_q[e][`CA_RXFC] <= flow_control_default_strap;
                end
                else if (hit && ofs == `CTRL_A_OFS)
                    ctrl_a_q[e] <= bus.wdata & `CA_WMASK;
            end

            // RULE12 strapped interface type
            // RULE7 strapped speed field
            always_ff @(posedge mclk or negedge rst_n)
            begin
                if (!rst_n)
                    ctrl_b_q[e] <= `CB_RST;
                else if (!strap_done_q)
                begin
                    ctrl_b_q[e][`CB_GIG]                 <= spd_strap[e];
                    ctrl_b_q[e][`CB_ROLE]                <= role_strap[e];
                    ctrl_b_q[e][`CB_TYPE_HI:`CB_TYPE_LO] <= type_strap[e];
                end
                else if (hit && ofs == `CTRL_B_OFS)
                    ctrl_b_q[e] <= bus.wdata & `CB_WMASK;
            end

            // Receive clock pin is sampled, never used as a clock
            link_sync3 u_rclk_sync
            (
                .mclk  (mclk),
                .rst_n (rst_n),
                .d     (receive_clock_pin_i[e]),
                .q     (rclk_s)
            );

            // Activity watch: any edge restarts the idle count
            always_ff @(posedge mclk or negedge rst_n)
            begin
                if (!rst_n)
                begin
                    rclk_prev_q          <= 1'b0;
                    idle_q               <= `RCLK_TIMEOUT;
                    link_clock_active[e] <= 1'b0;
                end
                else
                begin
                    rclk_prev_q <= rclk_s;
                    if (rclk_s != rclk_prev_q)
                        idle_q <= 6'h00;
                    else if (idle_q != `RCLK_TIMEOUT)
                        idle_q <= idle_q + 6'h01;
                    link_clock_active[e] <= (idle_q != `RCLK_TIMEOUT);
                end
            end

            // RULE10 RULE11 drive pin when role clear and type not RGMII
            always_ff @(posedge mclk or negedge rst_n)
            begin
                if (!rst_n)
                    drive_q <= 1'b0;
                else
                    drive_q <= strap_done_q && !ctrl_b_q[e][`CB_ROLE] &&
                               (ctrl_b_q[e][`CB_TYPE_HI:`CB_TYPE_LO] != 2'b00);
            end
            assign receive_clock_pin_oe[e] = drive_q;

            ref_clk_div u_ref_div
            (
                .mclk    (mclk),
                .rst_n   (rst_n),
                .en      (drive_q),
                .clk_out (receive_clock_pin_o[e])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Read path: data one cycle after the strobe, zero when unmapped
    always_comb
    begin
        rd_d = 8'h00;
        if (port_ok)
        begin
            unique case (ofs)
                `MAC_A_OFS:     rd_d = mac_a_q[pidx];
                `MAC_B_OFS:     rd_d = mac_b_q[pidx];
                `CTRL_A_OFS:    rd_d = ext_ok ? ctrl_a_q[eidx] : 8'h00;
                `CTRL_B_OFS:    rd_d = ext_ok ? ctrl_b_q[eidx] : 8'h00;
                `LINK_STAT_OFS: rd_d = ext_ok ? {7'h00, link_clock_active[eidx]} : 8'h00;
                default:        rd_d = 8'h00;
            endcase
        end
    end

    // Data stands only in the cycle after the read strobe
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            rdata <= 8'h00;
        else
            rdata <= bus.re ? rd_d : 8'h00;
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks on port 6 (external index 0, port index 5)
    default clocking cb_m @(posedge mclk); endclocking
    default disable iff (!rst_n);

    sequence s_wr_ca;
        bus.we && bus.addr == {4'h6, `CTRL_A_OFS};
    endsequence
    sequence s_wr_cb;
        bus.we && bus.addr == {4'h6, `CTRL_B_OFS};
    endsequence

    property p_duplex;
        s_wr_ca ##1 !bus.we[*1] |=> port_cfg[5].full_duplex == $past(ctrl_a_q[0][`CA_DUPLEX]);
    endproperty
    a_duplex: assert property (p_duplex) else $error("duplex not applied"); // RULE1
    property p_gig;
        s_wr_cb |-> ##2 (port_cfg[5].speed == SPD_1000) == !$past(bus.wdata[`CB_GIG], 2);
    endproperty
    a_gig: assert property (p_gig) else $error("gigabit decode wrong"); // RULE7
    property p_spd10;
        ctrl_b_q[0][`CB_GIG] && !ctrl_a_q[0][`CA_SPD100] |=> port_cfg[5].speed == SPD_10;
    endproperty
    a_spd10: assert property (p_spd10) else $error("10 speed wrong"); // RULE4
    property p_ign100;
        !ctrl_b_q[0][`CB_GIG] |=> port_cfg[5].speed == SPD_1000;
    endproperty
    a_ign100: assert property (p_ign100) else $error("10/100 not ignored"); // RULE3
    property p_bp;
        port_cfg[5].backpressure |-> !port_cfg[5].full_duplex;
    endproperty
    a_bp: assert property (p_bp) else $error("back pressure in full duplex"); // RULE14
    property p_strap;
        $rose(strap_done_q) |-> ctrl_b_q[0][`CB_TYPE_HI:`CB_TYPE_LO] == $past(type_strap[0])
            && ctrl_a_q[0][`CA_TXFC] == $past(flow_control_default_strap);
    endproperty
    a_strap: assert property (p_strap) else $error("strap not loaded"); // RULE6
    property p_role;
        strap_done_q && ctrl_b_q[0][`CB_ROLE] |-> ##1 !receive_clock_pin_oe[0];
    endproperty
    a_role: assert property (p_role) else $error("pin driven while clocks in"); // RULE10
    property p_rmii_out;
        strap_done_q && !ctrl_b_q[0][`CB_ROLE]
            && ctrl_b_q[0][`CB_TYPE_HI:`CB_TYPE_LO] == 2'b01 |=> receive_clock_pin_oe[0];
    endproperty
    a_rmii_out: assert property (p_rmii_out) else $error("reference not driven"); // RULE11
    property p_storm;
        bus.we && bus.addr == {4'h6, `MAC_A_OFS} |-> ##2
            port_cfg[5].storm_en == $past(bus.wdata[`MA_STORM], 2);
    endproperty
    a_storm: assert property (p_storm) else $error("storm enable wrong"); // RULE13
endmodule // port_mac_interface_config

// ### logic/port_mac_cfg_params.svh
// Constants for the port MAC and external interface configuration bank
`ifndef PORT_MAC_CFG_PARAMS_SVH
`define PORT_MAC_CFG_PARAMS_SVH
`define NPORTS        7
`define NEXT          2
`define EXT_BASE      5
`define EXT_LAST_IDX  3'd6
`define PORT_MIN      4'h1
`define PORT_MAX      4'h7
`define CTRL_A_OFS    12'h300
`define CTRL_B_OFS    12'h301
`define LINK_STAT_OFS 12'h3f0
`define MAC_A_OFS     12'h400
`define MAC_B_OFS     12'h401
`define CA_DUPLEX     6
`define CA_TXFC       5
`define CA_SPD100     4
`define CA_RXFC       3
`define CB_GIG        6
`define CB_RXDLY      4
`define CB_TXDLY      3
`define CB_ROLE       2
`define CB_TYPE_HI    1
`define CB_TYPE_LO    0
`define MA_STORM      1
`define MB_BACKPR     3
`define MB_PASSALL    0
`define CA_RST        8'h50
`define CA_WMASK      8'h7f
`define CB_RST        8'h08
`define CB_WMASK      8'hff
`define MA_RST        8'h00
`define MA_WMASK      8'h0b
`define MB_RST        8'h00
`define MB_WMASK      8'hbf
`define RCLK_TIMEOUT  6'd32
`define REF_HALF      2'd1
`endif

// ### logic/port_mac_cfg_pkg.sv
// Types shared by the port MAC configuration bank
package port_mac_cfg_pkg;
    typedef enum logic [1:0] {SPD_10, SPD_100, SPD_1000} speed_t;
    typedef enum logic [1:0] {IF_RGMII, IF_RMII, IF_MII} if_mode_t;
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  wdata;
        logic        we;
        logic        re;
    } bus_req_t;
    typedef struct packed {
        speed_t   speed;
        logic     full_duplex;
        logic     tx_fc_en;
        logic     rx_fc_en;
        logic     backpressure;
        logic     storm_en;
        logic     pass_bad;
        logic     rx_clock_delay_enable;
        logic     tx_clock_delay_enable;
        logic     clocks_in;
        if_mode_t mode;
    } port_cfg_t;
endpackage

// ### logic/link_sync3.sv
// Three-stage sampler for a pin from outside the clock domain
`timescale 1ns/1ps
module link_sync3
(
    input  wire logic mclk,
    input  wire logic rst_n,
    input  wire logic d,
    output logic      q
);
    logic s1_q;
    logic s2_q;
    logic s3_q;

    // Shift chain; the first stage feeds only the second
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
        end
        else
        begin
            s1_q <= d;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // A change counts only once stages two and three agree
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            q <= 1'b0;
        else if (s2_q == s3_q)
            q <= s3_q;
    end
endmodule // link_sync3

// ### logic/ref_clk_div.sv
// Divider that makes the reference clock driven out on the receive clock pin
`timescale 1ns/1ps
`include "port_mac_cfg_params.svh"
module ref_clk_div
(
    input  wire logic mclk,
    input  wire logic rst_n,
    input  wire logic en,
    output logic      clk_out
);
    logic [1:0] cnt_q;

    // Toggle every REF_HALF cycles; held low while disabled.
    // The true reference rate needs a PLL; this is the digital stand-in.
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt_q   <= 2'h0;
            clk_out <= 1'b0;
        end
        else if (!en)
        begin
            cnt_q   <= 2'h0;
            clk_out <= 1'b0;
        end
        else if (cnt_q == `REF_HALF - 2'd1)
        begin
            cnt_q   <= 2'h0;
            clk_out <= ~clk_out;
        end
        else
            cnt_q <= cnt_q + 2'd1;
    end
endmodule // ref_clk_div

// ### testbench/link_far_end.sv
// Far end model that clocks the receive clock pin of one external port
`timescale 1ns/1ps
module link_far_end
#(
    parameter real PHASE_NS = 37.0
)
(
    input  wire logic run,
    output logic      clk_out
);
    // far end clocks
    // Runs at 200 ns only while asked to; stands still low otherwise
    initial
    begin
        clk_out = 1'b0;
        #(PHASE_NS);
        forever
        begin
            #100;
            clk_out = run ? ~clk_out : 1'b0;
        end
    end
endmodule // link_far_end

// ### testbench/port_mac_interface_config_bench.sv
// Self-checking bench for the port MAC configuration bank
`timescale 1ns/1ps
`include "port_mac_cfg_params.svh"
module port_mac_interface_config_bench
    import port_mac_cfg_pkg::*;
;
    logic             mclk;
    logic             rst_n;
    bus_req_t         bus;
    logic [7:0]       rdata;
    logic [1:0]       pin_i;
    logic [1:0]       pin_o;
    logic [1:0]       pin_oe;
    logic [1:0]       active;
    logic [1:0]       far;
    logic [1:0]       run;
    port_cfg_t        cfg [`NPORTS];
    int               errors;
    int               comparisons;
    int               cycles;
    logic             t0;
    logic             fc_strap;
    logic [1:0]       type6_strap;
    ////////////////////////////////////////////////////////////////////////
    // Pin level resolves from the device enable and the far end
    assign pin_i[0] = pin_oe[0] ? pin_o[0] : far[0];
    assign pin_i[1] = pin_oe[1] ? pin_o[1] : far[1];
    port_mac_interface_config DUT (
        .mclk(mclk), .rst_n(rst_n), .bus(bus), .rdata(rdata),
        .flow_control_default_strap(fc_strap),
        .port6_speed_strap(1'b1), .port7_speed_strap(1'b0),
        .port6_clock_role_strap(1'b0), .port7_clock_role_strap(1'b1),
        .port6_interface_type_strap(type6_strap), .port7_interface_type_strap(2'b10),
        .receive_clock_pin_i(pin_i), .receive_clock_pin_o(pin_o),
        .receive_clock_pin_oe(pin_oe), .link_clock_active(active), .port_cfg(cfg));
    link_far_end #(.PHASE_NS(37.0)) far6 (.run(run[0]), .clk_out(far[0]));
    link_far_end #(.PHASE_NS(81.0)) far7 (.run(run[1]), .clk_out(far[1]));
    ////////////////////////////////////////////////////////////////////////
    // 40 MHz clock
    initial
    begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    // Cut a hang short well past the expected run length
    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            errors++;
            print_verdict();
        end
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp)
        begin
            $display("[ERR] %s expected %h seen %h", what, exp, got);
            errors++;
        end
    endtask
    // One-cycle write strobe; held until the taking edge
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge mclk);
        bus <= '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
        @(posedge mclk);
        bus.we <= 1'b0;
        @(posedge mclk);
        #1;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [15:0] a, input logic [7:0] exp, input string what);
        @(posedge mclk);
        bus <= '{addr: a, wdata: 8'h00, we: 1'b0, re: 1'b1};
        @(posedge mclk);
        bus.re <= 1'b0;
        #1;
        chk(what, exp, rdata);
    endtask
    task automatic print_verdict();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial
    begin
        rst_n <= 1'b0;
        bus <= '0;
        run <= 2'b00;
        fc_strap <= 1'b1;
        type6_strap <= 2'b01;
        errors = 0;
        comparisons = 0;
        cycles = 0;
        repeat (16) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (2) @(posedge mclk);
        // Strapped reset values
        rd(16'h6300, 8'h78, "p6 ctrl_a");
        rd(16'h7300, 8'h78, "p7 ctrl_a");
        rd(16'h6301, 8'h49, "p6 ctrl_b");
        rd(16'h7301, 8'h0e, "p7 ctrl_b");
        rd(16'h6400, 8'h00, "p6 mac_a");
        rd(16'h6401, 8'h00, "p6 mac_b");
        chk("p6 speed", {6'h0, SPD_100}, {6'h0, cfg[5].speed});
        chk("p7 speed", {6'h0, SPD_1000}, {6'h0, cfg[6].speed});
        chk("p6 mode", {6'h0, IF_RMII}, {6'h0, cfg[5].mode});
        chk("p7 clocks_in", 8'h01, {7'h0, cfg[6].clocks_in});
        chk("pin oe", 8'h01, {6'h0, pin_oe});
        t0 = pin_o[0];
        @(posedge mclk);
        #1;
        chk("p6 ref toggle", {7'h0, ~t0}, {7'h0, pin_o[0]});
        $display("test reset values done");
        // Writable masks and field effects
        wr(16'h6300, 8'hff);
        rd(16'h6300, 8'h7f, "p6 ctrl_a mask");
        wr(16'h6400, 8'hff);
        rd(16'h6400, 8'h0b, "p6 mac_a mask");
        wr(16'h6401, 8'hff);
        rd(16'h6401, 8'hbf, "p6 mac_b mask");
        chk("p6 storm", 8'h01, {7'h0, cfg[5].storm_en});
        chk("p6 pass", 8'h01, {7'h0, cfg[5].pass_bad});
        chk("p6 bp full", 8'h00, {7'h0, cfg[5].backpressure});
        chk("p6 fc", 8'h03, {6'h0, cfg[5].tx_fc_en, cfg[5].rx_fc_en});
        wr(16'h6300, 8'h00);
        chk("p6 duplex", 8'h00, {7'h0, cfg[5].full_duplex});
        chk("p6 bp half", 8'h01, {7'h0, cfg[5].backpressure});
        chk("p6 fc off", 8'h00, {6'h0, cfg[5].tx_fc_en, cfg[5].rx_fc_en});
        chk("p6 speed 10", {6'h0, SPD_10}, {6'h0, cfg[5].speed});
        wr(16'h6301, 8'h10);
        chk("p6 speed gig", {6'h0, SPD_1000}, {6'h0, cfg[5].speed});
        chk("p6 delays", 8'h02, {6'h0, cfg[5].rx_clock_delay_enable,
            cfg[5].tx_clock_delay_enable});
        $display("test field effects done");
        // Every interface type code, device role
        for (int c = 0; c < 4; c++)
        begin
            wr(16'h6301, 8'h40 | 8'(c));
            chk("p6 mode code", {6'h0, (c == 0) ? IF_RGMII : (c == 1) ? IF_RMII : IF_MII},
                {6'h0, cfg[5].mode});
            chk("p6 oe code", {7'h0, c != 0}, {7'h0, pin_oe[0]});
        end
        $display("test type codes done");
        // Unmapped places and internal ports
        rd(16'h6302, 8'h00, "p6 unmapped");
        rd(16'h0300, 8'h00, "port0");
        wr(16'h1300, 8'hff);
        rd(16'h1300, 8'h00, "p1 no ext");
        wr(16'h3400, 8'h02);
        wr(16'h3401, 8'h01);
        chk("p3 storm", 8'h01, {7'h0, cfg[2].storm_en});
        chk("p3 pass", 8'h01, {7'h0, cfg[2].pass_bad});
        $display("test unmapped done");
        // Far end clocks port 7 then port 6
        run[1] <= 1'b1;
        repeat (40) @(posedge mclk);
        #1;
        chk("p7 active", 8'h01, {7'h0, active[1]});
        rd(16'h73f0, 8'h01, "p7 link stat");
        run[1] <= 1'b0;
        repeat (45) @(posedge mclk);
        #1;
        chk("p7 idle", 8'h00, {7'h0, active[1]});
        wr(16'h6301, 8'h45);
        chk("p6 oe in", 8'h00, {7'h0, pin_oe[0]});
        run[0] <= 1'b1;
        repeat (40) @(posedge mclk);
        #1;
        chk("p6 active", 8'h01, {7'h0, active[0]});
        run[0] <= 1'b0;
        $display("test link clock done");
        // Second reset with other strap levels; straps settle while reset holds
        @(posedge mclk);
        rst_n <= 1'b0;
        fc_strap <= 1'b0;
        type6_strap <= 2'b11;
        repeat (16) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (2) @(posedge mclk);
        rd(16'h6300, 8'h50, "p6 ctrl_a restrap");
        rd(16'h6301, 8'h4b, "p6 ctrl_b restrap");
        chk("p6 fc restrap", 8'h00, {6'h0, cfg[5].tx_fc_en, cfg[5].rx_fc_en});
        chk("p6 mode restrap", {6'h0, IF_MII}, {6'h0, cfg[5].mode});
        chk("p6 oe mii", 8'h01, {7'h0, pin_oe[0]});
        $display("test second reset done");
        print_verdict();
    end
endmodule // port_mac_interface_config_bench
